// *** hdl/lps_regs.vh ***
`ifndef LPS_REGS_VH
`define LPS_REGS_VH
// register byte offsets
`define LPS_CTRL_OFF 5'h00
`define LPS_RATE_LO_OFF 5'h04
`define LPS_RATE_HI_OFF 5'h08
`define LPS_PROBE_OFF 5'h0c
`define LPS_STAT_OFF 5'h10
`define LPS_STAT_ADDR 5'h10
// ctrl fields
`define LPS_CTRL_ROLE 0
`define LPS_CTRL_PROBE_EN 1
`define LPS_CTRL_MULTI 2
`define LPS_CTRL_PAIRS_LSB 4
// probe fields
`define LPS_PR_DUR_LSB 0
`define LPS_PR_PBO1_LSB 8
`define LPS_PR_PBO2_LSB 12
`define LPS_PR_SCR_R_LSB 16
`define LPS_PR_SCR_C_LSB 20
// reset values: one 50 ms step, 6 dB back-off, scrambler index 0
`define LPS_CTRL_RST 32'h0000_0002
`define LPS_RATE_LO_RST 32'h0000_0001
`define LPS_RATE_HI_RST 32'h0000_0000
`define LPS_PROBE_RST 32'h0000_6601
// timing
`define LPS_CLK_NS 8
`define LPS_TICK_NS 1000000
`define LPS_GAP_MS 200
`define LPS_DUR_STEP_MS 50
`define LPS_DUR_MAX_STEPS 62
`define LPS_TOTAL_MAX_MS 10000
// rates: index k gives 192 + 64k kbit/s, line rate adds 8 kbit/s
`define LPS_NRATES 34
`define LPS_LINE_BASE_K 200
`define LPS_LINE_STEP_K 64
// 2^32 / (3 bits per symbol * 125000 kHz clock)
`define LPS_PHASE_K 32'd11453
// mapper levels in sixteenths, two's complement
`define LPS_LEVEL_POS 5'h09
`define LPS_LEVEL_NEG 5'h17
`endif

// *** hdl/lps_top.v ***
`timescale 1ns/1ns
`include "lps_regs.vh"

module lps_top #(
  parameter TICK_CYCLES = `LPS_TICK_NS / `LPS_CLK_NS,
  parameter NPAIRS = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire hs_end,
  output reg probe_done,
  output reg tx_sym_valid,
  output reg [4:0] tx_level,
  output reg [NPAIRS-1:0] tx_pair_en,
  output reg [5:0] tx_mask_sel,
  output reg [3:0] pbo_pair1,
  output reg [3:0] pbo_other
);

  localparam S_IDLE = 3'b001;
  localparam S_GAP = 3'b010;
  localparam S_BURST = 3'b100;
  localparam [NPAIRS-1:0] PAIR_ONE = {{(NPAIRS-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // register bus

  reg [31:0] ctrl_reg;
  reg [31:0] rate_lo_reg;
  reg [31:0] rate_hi_reg;
  reg [31:0] probe_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [4:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [31:0] stat_word;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_ok;
  wire wr_fire;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  always @* begin
    wr_ok = (aw_addr_reg[4:2] <= 3'd3);
    rd_ok = 1'b1;
    case (s_axi_araddr[4:2])
      3'd0: rd_word = ctrl_reg;
      3'd1: rd_word = rate_lo_reg;
      3'd2: rd_word = rate_hi_reg;
      3'd3: rd_word = probe_reg;
      3'd4: rd_word = stat_word;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `LPS_CTRL_RST;
      rate_lo_reg <= `LPS_RATE_LO_RST;
      rate_hi_reg <= `LPS_RATE_HI_RST;
      probe_reg <= `LPS_PROBE_RST;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        case (aw_addr_reg[4:2])
          3'd0: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
          3'd1: rate_lo_reg <= merge(rate_lo_reg, w_data_reg, w_strb_reg);
          3'd2: rate_hi_reg <= merge(rate_hi_reg, w_data_reg, w_strb_reg);
          3'd3: probe_reg <= merge(probe_reg, w_data_reg, w_strb_reg);
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  reg [2:0] state_reg;
  reg series_reg;
  reg last_gap_reg;
  reg [5:0] rate_reg;
  reg [`LPS_NRATES-1:0] mask_reg;
  reg role_reg;
  reg [5:0] dur_reg;
  reg [2:0] scr_sel_reg;
  reg overrun_reg;
  reg [31:0] tick_reg;
  reg [11:0] ms_reg;
  reg [13:0] total_reg;
  reg [22:0] scr_reg;
  reg [31:0] phase_reg;
  wire tick;
  wire [31:0] burst_ms;
  reg [6:0] nxt_hi, nxt_first, nxt_cfg;
  wire [5:0] dur_fix;
  wire [5:0] cfg_dur;

  function [6:0] find_rate;
    input [`LPS_NRATES-1:0] m;
    input [6:0] from;
    integer j;
    begin
      find_rate = 7'h00;
      for (j = `LPS_NRATES - 1; j >= 0; j = j - 1) begin
        if (m[j] && (j >= from)) begin
          find_rate = {1'b1, j[5:0]};
        end
      end
    end
  endfunction

  // ascending scan of the negotiated rate set
  always @* begin
    nxt_hi = find_rate(mask_reg, {1'b0, rate_reg} + 7'h01);
    nxt_first = find_rate(mask_reg, 7'h00);
    nxt_cfg = find_rate({rate_hi_reg[1:0], rate_lo_reg}, 7'h00);
  end

  // duration clamped to 1..62 steps of 50 ms
  assign cfg_dur = probe_reg[`LPS_PR_DUR_LSB +: 6];
  assign dur_fix = (cfg_dur == 6'h00) ? 6'h01 :
    (cfg_dur > `LPS_DUR_MAX_STEPS) ? 6'd62 : cfg_dur;
  assign burst_ms = dur_reg * `LPS_DUR_STEP_MS;

  // millisecond tick from the fixed clock
  assign tick = (tick_reg == TICK_CYCLES - 1);

  // tap masks, bit k-1 stands for s(n-k)
  function [22:0] taps;
    input central;
    input [2:0] idx;
    begin
      case ({central, idx})
        4'h8: taps = 23'h400010;
        4'h0: taps = 23'h420000;
        4'h9, 4'h1: taps = 23'h000001;
        4'ha: taps = 23'h000012;
        4'h2: taps = 23'h000014;
        4'hb: taps = 23'h000021;
        4'h3: taps = 23'h000030;
        4'hc: taps = 23'h000044;
        4'h4: taps = 23'h000048;
        4'hd: taps = 23'h00008e;
        4'h5: taps = 23'h0000b8;
        default: taps = 23'h000001;
      endcase
    end
  endfunction

  wire scr_bit = ~(^(scr_reg & taps(series_reg, scr_sel_reg)));
  wire [31:0] line_k = `LPS_LINE_BASE_K + rate_reg * `LPS_LINE_STEP_K;
  // symbol rate is line rate over three bits per symbol
  wire [32:0] phase_sum = {1'b0, phase_reg} +
    {1'b0, line_k * `LPS_PHASE_K};
  wire sending = (state_reg == S_BURST) && (series_reg == role_reg);

  always @* begin
    stat_word = 32'h0000_0000;
    stat_word[2:0] = state_reg;
    stat_word[4] = series_reg;
    stat_word[5] = sending;
    stat_word[13:8] = rate_reg;
    stat_word[16] = overrun_reg;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      series_reg <= 1'b0;
      last_gap_reg <= 1'b0;
      rate_reg <= 6'h00;
      mask_reg <= {`LPS_NRATES{1'b0}};
      role_reg <= 1'b0;
      dur_reg <= 6'h01;
      scr_sel_reg <= 3'h0;
      overrun_reg <= 1'b0;
      tick_reg <= 32'h0000_0000;
      ms_reg <= 12'h000;
      total_reg <= 14'h0000;
      scr_reg <= 23'h000000;
      phase_reg <= 32'h0000_0000;
      probe_done <= 1'b0;
    end else if (ce) begin
      probe_done <= 1'b0;
      tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      if (tick) begin
        ms_reg <= ms_reg + 12'h001;
        total_reg <= total_reg + 14'h0001;
      end
      case (state_reg)
        S_IDLE: begin
          tick_reg <= 32'h0000_0000;
          ms_reg <= 12'h000;
          total_reg <= 14'h0000;
          scr_reg <= 23'h000000;
          if (hs_end) begin
            mask_reg <= {rate_hi_reg[1:0], rate_lo_reg};
            role_reg <= ctrl_reg[`LPS_CTRL_ROLE];
            dur_reg <= dur_fix;
            scr_sel_reg <= probe_reg[`LPS_PR_SCR_R_LSB +: 3];
            rate_reg <= nxt_cfg[5:0];
            series_reg <= 1'b0;
            last_gap_reg <= 1'b0;
            overrun_reg <= 1'b0;
            // no line probe chosen, finish at once
            if (ctrl_reg[`LPS_CTRL_PROBE_EN] && nxt_cfg[6]) begin
              state_reg <= S_GAP;
            end else begin
              probe_done <= 1'b1;
            end
          end
        end
        S_GAP: begin
          // each gap timed from its start
          if (tick && (ms_reg == `LPS_GAP_MS - 1)) begin
            tick_reg <= 32'h0000_0000;
            ms_reg <= 12'h000;
            phase_reg <= 32'hffff_ffff;
            if (last_gap_reg) begin
              state_reg <= S_IDLE;
              probe_done <= 1'b1;
            end else begin
              state_reg <= S_BURST;
            end
          end
        end
        S_BURST: begin
          phase_reg <= phase_sum[31:0];
          if (sending && phase_sum[32]) begin
            scr_reg <= {scr_reg[21:0], scr_bit};
          end
          if (tick && (ms_reg == burst_ms - 1)) begin
            tick_reg <= 32'h0000_0000;
            ms_reg <= 12'h000;
            state_reg <= S_GAP;
            if (nxt_hi[6]) begin
              rate_reg <= nxt_hi[5:0];
            end else if (!series_reg) begin
              // central series uses its own polynomial
              series_reg <= 1'b1;
              rate_reg <= nxt_first[5:0];
              scr_sel_reg <= probe_reg[`LPS_PR_SCR_C_LSB +: 3];
            end else begin
              last_gap_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      // abandon a phase that would pass 10 s
      if ((state_reg != S_IDLE) && (total_reg >= `LPS_TOTAL_MAX_MS)) begin
        state_reg <= S_IDLE;
        overrun_reg <= 1'b1;
        probe_done <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line outputs

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_sym_valid <= 1'b0;
      tx_level <= 5'h00;
      tx_pair_en <= {NPAIRS{1'b0}};
      tx_mask_sel <= 6'h00;
      pbo_pair1 <= 4'h6;
      pbo_other <= 4'h6;
    end else if (ce) begin
      // one bit per symbol, silent outside bursts
      tx_sym_valid <= sending && phase_sum[32];
      // two levels of the data constellation
      if (sending && phase_sum[32]) begin
        tx_level <= scr_bit ? `LPS_LEVEL_POS : `LPS_LEVEL_NEG;
      end else if (!sending) begin
        tx_level <= 5'h00;
      end
      // pair one whenever sending, others in multi-pair mode
      if (sending) begin
        tx_pair_en <= ctrl_reg[`LPS_CTRL_MULTI] ?
          (ctrl_reg[`LPS_CTRL_PAIRS_LSB +: NPAIRS] | PAIR_ONE) : PAIR_ONE;
      end else begin
        tx_pair_en <= {NPAIRS{1'b0}};
      end
      // mask follows the burst rate index
      tx_mask_sel <= rate_reg;
      // first value to pair one, second to the rest
      pbo_pair1 <= probe_reg[`LPS_PR_PBO1_LSB +: 4];
      pbo_other <= probe_reg[`LPS_PR_PBO2_LSB +: 4];
    end
  end

endmodule // lps_top

// *** tb/lps_checker.sv ***
`timescale 1ns/1ns
module lps_checker #(
  parameter TICK_CYCLES = 125000,
  parameter NPAIRS = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire hs_end,
  input wire probe_done,
  input wire tx_sym_valid,
  input wire [4:0] tx_level,
  input wire [NPAIRS-1:0] tx_pair_en,
  input wire [5:0] tx_mask_sel,
  input wire [3:0] pbo_pair1,
  input wire [3:0] pbo_other
);
  reg busy_reg;
  reg [31:0] since_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // busy from accepted start to completion, cycles since start
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      since_reg <= 32'h0;
    end else if (hs_end && !busy_reg) begin
      busy_reg <= 1'b1;
      since_reg <= 32'h0;
    end else begin
      busy_reg <= busy_reg && !probe_done;
      since_reg <= since_reg + 32'h1;
    end
  end
  ////////////////////////////////////////
  AST_LEVEL: assert property (tx_sym_valid |->
    tx_level == 5'h09 || tx_level == 5'h17) else $error("bad level");
  AST_PAIR1: assert property (tx_sym_valid |-> tx_pair_en[0])
    else $error("pair one idle during symbol");
  AST_DONE_PULSE: assert property (probe_done |=> !probe_done)
    else $error("done longer than one cycle");
  AST_MASK: assert property (tx_sym_valid |-> tx_mask_sel < 6'd34)
    else $error("mask index out of range");
  AST_FIRST_GAP: assert property (tx_sym_valid |->
    since_reg >= 190 * TICK_CYCLES) else $error("symbol too early");
  AST_TOTAL: assert property (busy_reg |->
    since_reg < 10001 * TICK_CYCLES) else $error("probing too long");
  AST_SILENT: assert property (!busy_reg |-> !tx_sym_valid)
    else $error("symbol while idle");
  AST_SPACING: assert property (tx_sym_valid |=> !tx_sym_valid [*8])
    else $error("symbols too close");
  AST_RESET: assert property (disable iff (1'b0) !aresetn |=>
    pbo_pair1 == 4'h6 && pbo_other == 4'h6 && !probe_done)
    else $error("bad reset outputs");
endmodule // lps_checker

bind lps_top lps_checker #(.TICK_CYCLES(TICK_CYCLES), .NPAIRS(NPAIRS))
  lps_checker_inst (.aclk(aclk), .aresetn(aresetn), .hs_end(hs_end),
  .probe_done(probe_done), .tx_sym_valid(tx_sym_valid),
  .tx_level(tx_level), .tx_pair_en(tx_pair_en), .tx_mask_sel(tx_mask_sel),
  .pbo_pair1(pbo_pair1), .pbo_other(pbo_other));

// *** tb/lps_peer.sv ***
`timescale 1ns/1ns
module lps_peer (
  input wire aclk,
  input wire start,
  input wire central,
  input wire [2:0] scr_idx,
  output reg hs_end,
  input wire tx_sym_valid,
  input wire [4:0] tx_level,
  input wire [5:0] tx_mask_sel,
  input wire [3:0] tx_pair_en,
  input wire probe_done,
  output reg [31:0] t_first,
  output reg [31:0] t_done,
  output reg [15:0] n_sym,
  output reg [15:0] n_bad,
  output reg [5:0] k_first,
  output reg [5:0] k_last,
  output reg [3:0] pairs
);
  reg [31:0] t = 32'h0;
  reg [22:0] st = 23'h0;
  // tap masks of both ends, bit k-1 is the output k symbols back
  function [22:0] tapset(input c, input [2:0] x);
    case (x)
      3'd0: tapset = c ? 23'h400010 : 23'h420000;
      3'd2: tapset = c ? 23'h000012 : 23'h000014;
      3'd3: tapset = c ? 23'h000021 : 23'h000030;
      3'd4: tapset = c ? 23'h000044 : 23'h000048;
      3'd5: tapset = c ? 23'h00008e : 23'h0000b8;
      default: tapset = 23'h000001;
    endcase
  endfunction
  wire bit_n = ~(^(st & tapset(central, scr_idx)));
  wire [4:0] exp_lvl = bit_n ? 5'h09 : 5'h17;
  initial hs_end = 1'b0;
  always @(posedge aclk) begin
    hs_end <= start;
    t <= hs_end ? 32'h0 : t + 32'h1;
    if (hs_end) begin
      n_sym <= 16'h0;
      n_bad <= 16'h0;
      st <= 23'h0;
    end else if (tx_sym_valid) begin
      if (n_sym == 16'h0) begin
        t_first <= t;
        k_first <= tx_mask_sel;
        pairs <= tx_pair_en;
      end
      k_last <= tx_mask_sel;
      n_sym <= n_sym + 16'h1;
      // reference scrambler of the selected polynomial fed with ones
      if (tx_level !== exp_lvl) n_bad <= n_bad + 16'h1;
      st <= {st[21:0], bit_n};
    end
    if (probe_done) t_done <= t;
  end
endmodule // lps_peer

// *** tb/lps_top_test.sv ***
`timescale 1ns/1ns
`include "lps_regs.vh"
module lps_top_test;
  localparam TICK = 20;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [4:0] awaddr = 5'h0, araddr = 5'h0;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, start = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, hs_end, probe_done, sv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, t_first, t_done;
  wire [4:0] lvl;
  wire [3:0] pen, pbo1, pbo2, pairs;
  wire [5:0] msel, k_first, k_last;
  wire [15:0] n_sym, n_bad;
  integer n_fail = 0, checked = 0, i;
  reg [31:0] seed = 32'h6357, q, d, p1, p2, k1, k2;
  reg [1:0] r;
  reg [2:0] sr = 3'h0, sc = 3'h0;
  reg rl = 1'b0;
  wire [2:0] sx = rl ? sc : sr;
  always #4 aclk = ~aclk;
  lps_top #(.TICK_CYCLES(TICK), .NPAIRS(4)) lps_top_inst (.aclk(aclk),
    .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hs_end(hs_end), .probe_done(probe_done),
    .tx_sym_valid(sv), .tx_level(lvl), .tx_pair_en(pen), .tx_mask_sel(msel),
    .pbo_pair1(pbo1), .pbo_other(pbo2));
  lps_peer lps_peer_inst (.aclk(aclk), .start(start), .central(rl),
    .scr_idx(sx), .hs_end(hs_end),
    .tx_sym_valid(sv), .tx_level(lvl), .tx_mask_sel(msel), .tx_pair_en(pen),
    .probe_done(probe_done), .t_first(t_first), .t_done(t_done),
    .n_sym(n_sym), .n_bad(n_bad), .k_first(k_first), .k_last(k_last),
    .pairs(pairs));
  ////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  function [31:0] ser(input [31:0] dd);
    ser = 100 * dd + 200;
  endfunction
  function near(input [31:0] t, input [31:0] ms);
    near = (t + 10 * TICK >= ms * TICK) && (t <= ms * TICK + 10 * TICK);
  endfunction
  function [31:0] rst(input [1:0] k);
    case (k)
      2'd0: rst = `LPS_CTRL_RST;
      2'd1: rst = `LPS_RATE_LO_RST;
      2'd2: rst = `LPS_RATE_HI_RST;
      default: rst = `LPS_PROBE_RST;
    endcase
  endfunction
  task chk(input [8*9:1] nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task ax(input wr, input [4:0] a, input [31:0] dd, output [31:0] qq,
    output [1:0] rr);
    reg t0, t1, t2;
    begin
      t2 = 1'b0;
      if (wr) begin
        awaddr <= a;
        wdata <= dd;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
      end else begin
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
      end
      while (!t2) begin
        @(negedge aclk);
        t0 = wr ? (awvalid & awready) : (arvalid & arready);
        t1 = wvalid & wready;
        t2 = wr ? bvalid : rvalid;
        qq = rdata;
        rr = wr ? bresp : rresp;
        @(posedge aclk);
        if (t0) begin
          awvalid <= 1'b0;
          arvalid <= 1'b0;
        end
        if (t1) wvalid <= 1'b0;
        if (t2) begin
          bready <= 1'b0;
          rready <= 1'b0;
        end
      end
      @(posedge aclk);
    end
  endtask
  task go;
    integer j;
    begin
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      for (j = 0; j < 40000 && probe_done !== 1'b1; j = j + 1)
        @(posedge aclk);
      repeat (3) @(posedge aclk);
    end
  endtask
  task run_seq(input [31:0] role);
    begin
      seed = xs(seed);
      k1 = 24 + seed[1:0];
      k2 = 28 + seed[3:2];
      p1 = seed[7:4];
      p2 = seed[11:8];
      d = 1 + seed[12];
      sr = 3'd2 + seed[14:13];
      sc = 3'd5 - seed[14:13];
      rl = role[0];
      ax(1, `LPS_RATE_LO_OFF, (32'h1 << k1) | (32'h1 << k2), q, r);
      // each series gets its own polynomial index
      ax(1, `LPS_PROBE_OFF, (sc << 20) | (sr << 16) | (p2 << 12) |
        (p1 << 8) | d, q, r);
      ax(1, `LPS_CTRL_OFF, 32'h26 | role, q, r);
      chk("pbo1", p1, pbo1);
      chk("pbo2", p2, pbo2);
      go;
      chk("first", 1, near(t_first, role ? 400 + ser(d) : 200));
      chk("done", 1, near(t_done, 600 + 2 * ser(d)));
      chk("k_first", k1, k_first);
      chk("k_last", k2, k_last);
      chk("levels", 0, n_bad);
      chk("symbols", 1, n_sym >= 4);
      chk("pairs", 4'h3, pairs);
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pbo1", 6, pbo1);
    for (i = 0; i < 4; i = i + 1) begin
      ax(0, {i[2:0], 2'b00}, 0, q, r);
      chk("reset", rst(i[1:0]), q);
    end
    ax(0, `LPS_STAT_ADDR, 0, q, r);
    chk("idle", 1, q[2:0]);
    ax(0, 5'h14, 0, q, r);
    chk("unmapped", 2, r);
    chk("unmapdat", 0, q);
    ax(1, `LPS_STAT_ADDR, 32'hffff_ffff, q, r);
    chk("readonly", 2, r);
    ax(1, `LPS_CTRL_OFF, 0, q, r);
    go;
    chk("skipdone", 1, t_done <= 2);
    chk("skipsym", 0, n_sym);
    run_seq(0);
    run_seq(1);
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge aclk);
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule // lps_top_test
